/* File: shared/dual_timer_map.vh */
// Purpose: Register map, field positions and constants of the dual timer.
// Assumes: Plain Verilog-2005; included by bare name.
// Notes:   Register offsets are word indices on an 8-bit plain port.
`ifndef DUAL_TIMER_MAP_VH
`define DUAL_TIMER_MAP_VH

// Register offsets
`define ADDR_W              4
`define OFS_CONTROL_STATUS  4'h0
`define OFS_MODE_CONFIG     4'h1
`define OFS_CLOCK_SELECT    4'h2
`define OFS_T0_LOW          4'h3
`define OFS_T0_HIGH         4'h4
`define OFS_T1_LOW          4'h5
`define OFS_T1_HIGH         4'h6
`define OFS_IRQ_STATUS      4'h7
`define OFS_IRQ_MASK        4'h8

// Reset values
`define RST_BYTE            8'h00
`define RST_NIBBLE          4'h0

// timer_control_status fields
`define CS_TF1              7
`define CS_TR1              6
`define CS_TF0              5
`define CS_TR0              4
`define CS_IE1              3
`define CS_IT1              2
`define CS_IE0              1
`define CS_IT0              0

// timer_mode_config fields
`define MC_TIMER1_GATE_ENABLE            7
`define MC_CT1              6
`define MC_T1MODE_HI        5
`define MC_T1MODE_LO        4
`define MC_TIMER0_GATE_ENABLE            3
`define MC_CT0              2
`define MC_T0MODE_HI        1
`define MC_T0MODE_LO        0

// clock_select fields
`define CK_T1M              4
`define CK_T0M              3

// irq_status / irq_mask fields
`define IRQ_TF0             0
`define IRQ_TF1             1
`define IRQ_IE0             2
`define IRQ_IE1             3

// Timer modes
`define MODE_13BIT          2'h0
`define MODE_16BIT          2'h1
`define MODE_AUTORELOAD     2'h2
`define MODE_SPLIT          2'h3

// Counting constants
`define BYTE_ONES           8'hFF
`define LOW5_ONES           5'h1F
`define INC9                9'h001
`define INC14               14'h0001
`define INC17               17'h00001
`define PRESCALE_DIV        4'hC
`define PRESCALE_LAST       4'hB
`define PRESCALE_ZERO       4'h0
`define PRESCALE_STEP       4'h1

`endif

/* File: hdl/fall_sampler.v */
// Purpose: Samples a pin on the system clock and flags high-to-low moves.
// Assumes: Pin is synchronous to core_clk.
// Notes:   One pulse per transition; pulse is one cycle wide.
`timescale 1ns/10ps
`include "dual_timer_map.vh"

module fall_sampler (
	// Clock and reset
	input  wire core_clk,
	input  wire resetn,
	// Pin and event
	input  wire pin,
	output reg  level,
	output wire fall
);
	reg older;

	// Two consecutive samples give one event per transition
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			level <= 1'b1;
			older <= 1'b1;
		end else begin
			level <= pin;
			older <= level;
		end
	end

	assign fall = older & ~level;
endmodule // fall_sampler

/* File: hdl/dual_timer.v */
// Purpose: Two 8051-style counter/timers with split mode for the first.
// Assumes: Single clock; pins synchronous; registers on an 8-bit plain port.
// Notes:   Read data stands one cycle after the read strobe.
// Behaviour
// - Split mode runs first timer's low and high bytes as separate 8-bit counters.
// - Split low byte uses first timer's run, count-select, gate and overflow flag.
// - Split low byte counts internal clock or count pin falls per count-select.
// - Split high byte is a timer only, on system or prescaled clock.
// - Split high byte runs on second timer's run bit alone.
// - Split high byte overflow sets second timer's flag and its interrupt.
// - Second timer in mode 3 is inactive and holds its count.
// - During split, second timer ignores external clocks and never sets its flag.
// - During split, second timer overflow pulse still leaves as baud/start source.
// - During split, second timer runs in modes 0-2, stops in mode 3.
// - Run bit set counts only if gate clear or gate input high.
// - Count-select 1 counts pin falls, 0 uses clock chosen by clock-select.
// - Counter overflow sets the timer's flag and requests an interrupt if enabled.
`timescale 1ns/10ps
`include "dual_timer_map.vh"

module dual_timer (
	// Clock and reset
	input  wire                 core_clk,
	input  wire                 resetn,
	// Register port
	input  wire [`ADDR_W-1:0]   reg_addr,
	input  wire [7:0]           reg_wdata,
	input  wire                 reg_write,
	input  wire                 reg_read,
	output reg  [7:0]           reg_rdata,
	// External pins
	input  wire                 count_pin_0,
	input  wire                 count_pin_1,
	input  wire                 ext_input0_n,
	input  wire                 ext_input1_n,
	// Vector acknowledge pulses
	input  wire                 timer0_vector_ack,
	input  wire                 timer1_vector_ack,
	input  wire                 ext_ext_input0_n_vector_ack,
	input  wire                 ext_ext_input1_n_vector_ack,
	// Outputs
	output reg                  irq,
	output reg                  timer1_overflow_pulse
);
	// Register state
	reg  [7:0] timer_control_status;
	reg  [7:0] timer_mode_config;
	reg  [7:0] clock_select;
	reg  [7:0] t0_low_byte;
	reg  [7:0] t0_high_byte;
	reg  [7:0] t1_low_byte;
	reg  [7:0] t1_high_byte;
	reg  [3:0] irq_status;
	reg  [3:0] irq_mask;
	reg  [3:0] prescale_count;
	reg        prescale_tick;

	// Next values
	reg  [7:0] next_t0_low;
	reg  [7:0] next_t0_high;
	reg  [7:0] next_t1_low;
	reg  [7:0] next_t1_high;
	reg  [7:0] next_control_status;
	reg  [3:0] next_irq_status;
	reg  [7:0] next_rdata;
	reg        t0_ovf;
	reg        th0_ovf;
	reg        t1_ovf;
	reg        t1_go;
	reg  [3:0] irq_events;

	// Sampled pins
	wire       cnt0_fall;
	wire       cnt1_fall;
	wire       timer0_gate_enable_level;
	wire       timer1_gate_enable_level;
	wire       ext0_fall;
	wire       ext1_fall;

	// Field views
	wire       timer0_run          = timer_control_status[`CS_TR0];
	wire       timer1_run          = timer_control_status[`CS_TR1];
	wire       timer0_overflow_flag = timer_control_status[`CS_TF0];
	wire       timer1_overflow_flag = timer_control_status[`CS_TF1];
	wire       ext_ext_input0_n_flag       = timer_control_status[`CS_IE0];
	wire       ext_ext_input1_n_flag       = timer_control_status[`CS_IE1];
	wire       ext_ext_input0_n_edge_select = timer_control_status[`CS_IT0];
	wire       ext_ext_input1_n_edge_select = timer_control_status[`CS_IT1];
	wire       timer0_gate_enable  = timer_mode_config[`MC_TIMER0_GATE_ENABLE];
	wire       timer1_gate_enable  = timer_mode_config[`MC_TIMER1_GATE_ENABLE];
	wire       timer0_count_select = timer_mode_config[`MC_CT0];
	wire       timer1_count_select = timer_mode_config[`MC_CT1];
	wire [1:0] timer0_mode_field   = {timer_mode_config[`MC_T0MODE_HI],
	                                  timer_mode_config[`MC_T0MODE_LO]};
	wire [1:0] timer1_mode_field   = {timer_mode_config[`MC_T1MODE_HI],
	                                  timer_mode_config[`MC_T1MODE_LO]};
	wire       timer0_clock_select = clock_select[`CK_T0M];
	wire       timer1_clock_select = clock_select[`CK_T1M];

	wire       split = (timer0_mode_field == `MODE_SPLIT);

	// Bus decode
	wire       wr_cs   = reg_write && (reg_addr == `OFS_CONTROL_STATUS);
	wire       wr_mc   = reg_write && (reg_addr == `OFS_MODE_CONFIG);
	wire       wr_ck   = reg_write && (reg_addr == `OFS_CLOCK_SELECT);
	wire       wr_t0l  = reg_write && (reg_addr == `OFS_T0_LOW);
	wire       wr_t0h  = reg_write && (reg_addr == `OFS_T0_HIGH);
	wire       wr_t1l  = reg_write && (reg_addr == `OFS_T1_LOW);
	wire       wr_t1h  = reg_write && (reg_addr == `OFS_T1_HIGH);
	wire       wr_ist  = reg_write && (reg_addr == `OFS_IRQ_STATUS);
	wire       wr_imk  = reg_write && (reg_addr == `OFS_IRQ_MASK);

	// Internal timebases: system clock every cycle, or prescaled tick
	wire       int_tick0 = timer0_clock_select | prescale_tick;
	wire       int_tick1 = timer1_clock_select | prescale_tick;

	// Gating by run bit and gate input
	wire       en0 = timer0_run & (~timer0_gate_enable | timer0_gate_enable_level);
	wire       en1 = timer1_run & (~timer1_gate_enable | timer1_gate_enable_level);

	// Source selection by count-select
	wire       src0 = timer0_count_select ? cnt0_fall : int_tick0;
	wire       src1 = timer1_count_select ? cnt1_fall : int_tick1;
	wire       tick0 = en0 & src0;

	// Pin samplers
	// Count pins need only the fall event, so their level is left open
	fall_sampler u_cnt0 (
		.core_clk (core_clk),
		.resetn   (resetn),
		.pin      (count_pin_0),
		.level    (),
		.fall     (cnt0_fall)
	);
	fall_sampler u_cnt1 (
		.core_clk (core_clk),
		.resetn   (resetn),
		.pin      (count_pin_1),
		.level    (),
		.fall     (cnt1_fall)
	);
	fall_sampler u_ext0 (
		.core_clk (core_clk),
		.resetn   (resetn),
		.pin      (ext_input0_n),
		.level    (timer0_gate_enable_level),
		.fall     (ext0_fall)
	);
	fall_sampler u_ext1 (
		.core_clk (core_clk),
		.resetn   (resetn),
		.pin      (ext_input1_n),
		.level    (timer1_gate_enable_level),
		.fall     (ext1_fall)
	);

	// One count step in modes 0, 1 and 2; mode 3 holds
	function [16:0] step;
		input [1:0] mode;
		input [7:0] hi;
		input [7:0] lo;
		reg   [13:0] s13;
		begin
			s13 = {1'b0, hi, lo[4:0]} + `INC14;
			case (mode)
				`MODE_13BIT: begin
					// Upper three bits of the low byte are left untouched
					step = {s13[13], s13[12:5], lo[7:5], s13[4:0]};
				end
				`MODE_16BIT: begin
					step = {1'b0, hi, lo} + `INC17;
				end
				`MODE_AUTORELOAD: begin
					if (lo == `BYTE_ONES)
						step = {1'b1, hi, hi};
					else
						step = {1'b0, hi, lo + 8'h01};
				end
				default: begin
					step = {1'b0, hi, lo};
				end
			endcase
		end
	endfunction

	// Counting and flag logic
	always @* begin
		next_t0_low  = t0_low_byte;
		next_t0_high = t0_high_byte;
		next_t1_low  = t1_low_byte;
		next_t1_high = t1_high_byte;
		t0_ovf       = 1'b0;
		th0_ovf      = 1'b0;
		t1_ovf       = 1'b0;

		if (split) begin
			// Low byte: own controls and selected source
			if (tick0)
				{t0_ovf, next_t0_low} = {1'b0, t0_low_byte} + `INC9;
			// High byte: second timer's run bit, internal clock only
			if (timer1_run && int_tick0)
				{th0_ovf, next_t0_high} = {1'b0, t0_high_byte} + `INC9;
		end else if (tick0) begin
			{t0_ovf, next_t0_high, next_t0_low} =
				step(timer0_mode_field, t0_high_byte, t0_low_byte);
		end

		// Second timer: run follows its mode during split, never a pin
		if (split)
			t1_go = (timer1_mode_field != `MODE_SPLIT) & int_tick1;
		else
			t1_go = en1 & src1;
		if (t1_go)
			{t1_ovf, next_t1_high, next_t1_low} =
				step(timer1_mode_field, t1_high_byte, t1_low_byte);

		// Software writes win over counting
		if (wr_t0l)
			next_t0_low = reg_wdata;
		if (wr_t0h)
			next_t0_high = reg_wdata;
		if (wr_t1l)
			next_t1_low = reg_wdata;
		if (wr_t1h)
			next_t1_high = reg_wdata;
	end

	// Control/status next value; a hardware set wins over any clear
	always @* begin
		next_control_status = timer_control_status;
		if (wr_cs)
			next_control_status = reg_wdata;
		else begin
			if (timer0_vector_ack)
				next_control_status[`CS_TF0] = 1'b0;
			if (timer1_vector_ack)
				next_control_status[`CS_TF1] = 1'b0;
			if (ext_ext_input0_n_vector_ack && ext_ext_input0_n_edge_select)
				next_control_status[`CS_IE0] = 1'b0;
			if (ext_ext_input1_n_vector_ack && ext_ext_input1_n_edge_select)
				next_control_status[`CS_IE1] = 1'b0;
		end
		if (t0_ovf)
			next_control_status[`CS_TF0] = 1'b1;
		// During split only the high byte may set the second flag
		if (split ? th0_ovf : t1_ovf)
			next_control_status[`CS_TF1] = 1'b1;
		if (ext_ext_input0_n_edge_select) begin
			if (ext0_fall)
				next_control_status[`CS_IE0] = 1'b1;
		end else begin
			next_control_status[`CS_IE0] = ~timer0_gate_enable_level;
		end
		if (ext_ext_input1_n_edge_select) begin
			if (ext1_fall)
				next_control_status[`CS_IE1] = 1'b1;
		end else begin
			next_control_status[`CS_IE1] = ~timer1_gate_enable_level;
		end
	end

	// Interrupt events: rising of each flag
	always @* begin
		irq_events = `RST_NIBBLE;
		irq_events[`IRQ_TF0] = next_control_status[`CS_TF0] & ~timer0_overflow_flag;
		irq_events[`IRQ_TF1] = next_control_status[`CS_TF1] & ~timer1_overflow_flag;
		irq_events[`IRQ_IE0] = next_control_status[`CS_IE0] & ~ext_ext_input0_n_flag;
		irq_events[`IRQ_IE1] = next_control_status[`CS_IE1] & ~ext_ext_input1_n_flag;
		next_irq_status = irq_status;
		if (wr_ist)
			next_irq_status = irq_status & ~reg_wdata[3:0];
		next_irq_status = next_irq_status | irq_events;
	end

	// Read multiplexer; unmapped offsets read zero
	always @* begin
		case (reg_addr)
			`OFS_CONTROL_STATUS: next_rdata = timer_control_status;
			`OFS_MODE_CONFIG:    next_rdata = timer_mode_config;
			`OFS_CLOCK_SELECT:   next_rdata = clock_select;
			`OFS_T0_LOW:         next_rdata = t0_low_byte;
			`OFS_T0_HIGH:        next_rdata = t0_high_byte;
			`OFS_T1_LOW:         next_rdata = t1_low_byte;
			`OFS_T1_HIGH:        next_rdata = t1_high_byte;
			`OFS_IRQ_STATUS:     next_rdata = {4'h0, irq_status};
			`OFS_IRQ_MASK:       next_rdata = {4'h0, irq_mask};
			default:             next_rdata = `RST_BYTE;
		endcase
	end

	// Prescaler: one tick every PRESCALE_DIV system clocks
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			prescale_count <= `PRESCALE_ZERO;
			prescale_tick  <= 1'b0;
		end else if (prescale_count == `PRESCALE_LAST) begin
			prescale_count <= `PRESCALE_ZERO;
			prescale_tick  <= 1'b1;
		end else begin
			prescale_count <= prescale_count + `PRESCALE_STEP;
			prescale_tick  <= 1'b0;
		end
	end

	// State registers
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			timer_control_status  <= `RST_BYTE;
			timer_mode_config     <= `RST_BYTE;
			clock_select          <= `RST_BYTE;
			t0_low_byte           <= `RST_BYTE;
			t0_high_byte          <= `RST_BYTE;
			t1_low_byte           <= `RST_BYTE;
			t1_high_byte          <= `RST_BYTE;
			irq_status            <= `RST_NIBBLE;
			irq_mask              <= `RST_NIBBLE;
			reg_rdata             <= `RST_BYTE;
			irq                   <= 1'b0;
			timer1_overflow_pulse <= 1'b0;
		end else begin
			timer_control_status <= next_control_status;
			if (wr_mc)
				timer_mode_config <= reg_wdata;
			// Only the two clock-select bits are kept
			if (wr_ck)
				clock_select <= reg_wdata & ((8'h01 << `CK_T1M) | (8'h01 << `CK_T0M));
			if (wr_imk)
				irq_mask <= reg_wdata[3:0];
			t0_low_byte  <= next_t0_low;
			t0_high_byte <= next_t0_high;
			t1_low_byte  <= next_t1_low;
			t1_high_byte <= next_t1_high;
			irq_status   <= next_irq_status;
			// Output stays registered; follows status one cycle later
			irq          <= |(irq_status & irq_mask);
			if (reg_read)
				reg_rdata <= next_rdata;
			else
				reg_rdata <= `RST_BYTE;
			// Overflow pulse leaves even while the flag is withheld
			timer1_overflow_pulse <= t1_ovf;
		end
	end
endmodule // dual_timer

/* File: verification/dual_timer_asserts.sv */
// Purpose: Port-level checker for the dual timer.
// Assumes: Shadows of written registers stand in for the hidden state.
// Notes:   Quiet counters hold off checks until flag and irq lag settles.
`timescale 1ns/10ps
`include "dual_timer_map.vh"
module dual_timer_asserts (
	// Clock and reset
	input wire logic               core_clk,
	input wire logic               resetn,
	// Register port
	input wire logic [`ADDR_W-1:0] reg_addr,
	input wire logic [7:0]         reg_wdata,
	input wire logic               reg_write,
	input wire logic               reg_read,
	input wire logic [7:0]         reg_rdata,
	// Pins and outputs
	input wire logic               count_pin_0,
	input wire logic               ext_input0_n,
	input wire logic               irq,
	input wire logic               timer1_overflow_pulse
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	logic [7:0] cs, mc, ck, msk;
	logic [2:0] q0, q1, st0;
	logic       e0q, itd;
	wire wcs = reg_write && reg_addr == `OFS_CONTROL_STATUS;
	wire split = mc[1:0] == `MODE_SPLIT;
	wire m13 = mc[5:4] == `MODE_SPLIT;
	wire stop0 = msk == 8'h01 && !wcs && (!cs[`CS_TR0] || (mc[`MC_TIMER0_GATE_ENABLE] && !ext_input0_n)
		|| (mc[`MC_CT0] && count_pin_0));
	wire stop1 = split && msk == 8'h02 && !wcs && !cs[`CS_TR1];
	wire run0 = mc[1:0] == `MODE_AUTORELOAD && cs[`CS_TR0] && !mc[`MC_CT0] && ck[`CK_T0M]
		&& (!mc[`MC_TIMER0_GATE_ENABLE] || ext_input0_n) && msk == 8'h01 && !wcs;
	wire run1 = split && cs[`CS_TR1] && ck[`CK_T0M] && msk == 8'h02 && !wcs;
	wire runt = split && mc[5:4] == `MODE_AUTORELOAD && ck[`CK_T1M];
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			{cs, mc, ck, msk} <= '0;
			{q0, q1, st0, e0q, itd} <= '0;
		end else begin
			if (wcs)
				cs <= reg_wdata;
			if (reg_write && reg_addr == `OFS_MODE_CONFIG)
				mc <= reg_wdata;
			if (reg_write && reg_addr == `OFS_CLOCK_SELECT)
				ck <= reg_wdata;
			if (reg_write && reg_addr == `OFS_IRQ_MASK)
				msk <= reg_wdata & 8'h0F;
			q0 <= !stop0 ? 3'h0 : (q0 == 3'h7 ? q0 : q0 + 3'h1);
			q1 <= !stop1 ? 3'h0 : (q1 == 3'h7 ? q1 : q1 + 3'h1);
			st0 <= (ext_input0_n != e0q) ? 3'h0 : (st0 == 3'h7 ? st0 : st0 + 3'h1);
			e0q <= ext_input0_n;
			itd <= cs[`CS_IT0];
		end
	end
	AST_T1_PARKED: assert property (m13 && $past(m13) && $past(m13, 2) |-> !timer1_overflow_pulse)
		else $error("second timer overflowed while parked");
	AST_T1_SPLIT_RUNS: assert property ($rose(runt) |-> ##[1:270] (timer1_overflow_pulse || !runt))
		else $error("second timer idle in split mode");
	AST_IE0_LEVEL: assert property (reg_read && reg_addr == `OFS_CONTROL_STATUS && !cs[`CS_IT0]
		&& !itd && st0 >= 3'h3 |=> reg_rdata[`CS_IE0] == !$past(ext_input0_n))
		else $error("level flag does not follow input");
	AST_TH0_OVF_IRQ: assert property ($rose(run1) |-> ##[1:270] (irq || !run1))
		else $error("high byte overflow gave no interrupt");
	AST_TL0_OVF_IRQ: assert property ($rose(run0) |-> ##[1:270] (irq || !run0))
		else $error("first timer overflow gave no interrupt");
	AST_GATE_HOLDS: assert property (q0 >= 3'h5 && mc[`MC_TIMER0_GATE_ENABLE] && !irq |=> !irq)
		else $error("gated timer overflowed");
	AST_PIN_QUIET: assert property (q0 >= 3'h5 && mc[`MC_CT0] && !irq |=> !irq)
		else $error("counter moved without pin falls");
	AST_TH0_NEEDS_RUN: assert property (q1 >= 3'h5 && !irq |=> !irq)
		else $error("high byte ran without its run bit");
endmodule // dual_timer_asserts
bind dual_timer dual_timer_asserts i_chk (.core_clk(core_clk), .resetn(resetn),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
	.reg_rdata(reg_rdata), .count_pin_0(count_pin_0), .ext_input0_n(ext_input0_n),
	.irq(irq), .timer1_overflow_pulse(timer1_overflow_pulse));

/* File: verification/pin_model.sv */
// Purpose: Far-side pins: count inputs and active-low gate input.
// Assumes: Pins change just after core_clk edges.
// Notes:   Lines idle high as with a pull-up.
`timescale 1ns/10ps
module pin_model (
	// Clock
	input  wire logic core_clk,
	// Pins
	output logic      count_pin_0,
	output logic      count_pin_1,
	output logic      ext_input0_n,
	output logic      ext_input1_n
);
	initial begin
		{count_pin_0, count_pin_1, ext_input0_n, ext_input1_n} = 4'hF;
	end
	task automatic falls(input int pin, input int n);
		repeat (n) begin
			@(posedge core_clk);
			if (pin == 0)
				count_pin_0 <= 1'b0;
			else
				count_pin_1 <= 1'b0;
			repeat (3) @(posedge core_clk);
			count_pin_0 <= 1'b1;
			count_pin_1 <= 1'b1;
			repeat (3) @(posedge core_clk);
		end
	endtask
	task automatic set_gate(input logic v);
		@(posedge core_clk);
		ext_input0_n <= v;
	endtask
endmodule // pin_model

/* File: verification/tb_top.sv */
// Purpose: Self-checking bench for the dual timer split mode.
// Assumes: Pins come from pin_model; register port per plain contract.
// Notes:   Timers run on the system clock to keep waits short.
`timescale 1ns/10ps
`include "dual_timer_map.vh"
module tb_top;
	logic               core_clk;
	logic               resetn;
	logic [`ADDR_W-1:0] reg_addr;
	logic [7:0]         reg_wdata;
	logic               reg_write;
	logic               reg_read;
	logic [7:0]         reg_rdata;
	logic               t1_ack;
	logic               t0_ack;
	logic               irq;
	logic               t1_pulse;
	logic               hit;
	wire                cp0, cp1, e0n, e1n;
	int                 err_count;
	int                 n_compared;
	pin_model i_pins (.core_clk(core_clk), .count_pin_0(cp0), .count_pin_1(cp1),
		.ext_input0_n(e0n), .ext_input1_n(e1n));
	dual_timer i_dut (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .count_pin_0(cp0), .count_pin_1(cp1), .ext_input0_n(e0n),
		.ext_input1_n(e1n), .timer0_vector_ack(t0_ack), .timer1_vector_ack(t1_ack),
		.ext_ext_input0_n_vector_ack(1'b0), .ext_ext_input1_n_vector_ack(1'b0), .irq(irq),
		.timer1_overflow_pulse(t1_pulse));
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge core_clk);
		reg_write <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge core_clk);
		reg_read <= 1'b0;
		@(posedge core_clk);
		chk("reg_rdata", reg_rdata, exp);
	endtask
	// One-cycle vector acknowledge; which 0 is the first timer, 1 the second
	task automatic ack(input int which);
		@(posedge core_clk);
		if (which == 0)
			t0_ack <= 1'b1;
		else
			t1_ack <= 1'b1;
		@(posedge core_clk);
		t0_ack <= 1'b0;
		t1_ack <= 1'b0;
	endtask
	// Bounded wait; which 0 is irq, 1 is the second timer pulse
	task automatic wait_for(input int which);
		hit = 1'b0;
		for (int i = 0; i < 300 && !hit; i++) begin
			@(posedge core_clk);
			hit = (which == 0) ? (irq === 1'b1) : (t1_pulse === 1'b1);
		end
	endtask
	task automatic t_reset_map();
		for (int a = 0; a < 9; a++)
			rd(a[3:0], 8'h00);
		wr(4'hF, 8'hAA);
		rd(4'hF, 8'h00);
		#1 chk("idle rdata", reg_rdata, 8'h00);
	endtask
	task automatic t_split_low();
		wr(`OFS_MODE_CONFIG, 8'h07);
		wr(`OFS_T0_HIGH, 8'h55);
		wr(`OFS_T0_LOW, 8'hFE);
		wr(`OFS_IRQ_MASK, 8'h01);
		wr(`OFS_CONTROL_STATUS, 8'h10);
		repeat (10) @(posedge core_clk);
		chk("irq", {7'h0, irq}, 8'h00);
		i_pins.falls(0, 3);
		rd(`OFS_T0_LOW, 8'h01);
		rd(`OFS_CONTROL_STATUS, 8'h30);
		chk("irq", {7'h0, irq}, 8'h01);
		rd(`OFS_T0_HIGH, 8'h55);
		ack(0);
		rd(`OFS_CONTROL_STATUS, 8'h10);
		wr(`OFS_CONTROL_STATUS, 8'h00);
		wr(`OFS_IRQ_STATUS, 8'h0F);
	endtask
	task automatic t_split_high();
		wr(`OFS_T0_LOW, 8'h12);
		wr(`OFS_T0_HIGH, 8'hF0);
		wr(`OFS_CLOCK_SELECT, 8'h08);
		wr(`OFS_IRQ_MASK, 8'h02);
		wr(`OFS_CONTROL_STATUS, 8'h10);
		repeat (10) @(posedge core_clk);
		chk("irq", {7'h0, irq}, 8'h00);
		wr(`OFS_CONTROL_STATUS, 8'h50);
		wait_for(0);
		chk("irq", {7'h0, hit}, 8'h01);
		rd(`OFS_CONTROL_STATUS, 8'hD0);
		rd(`OFS_T0_LOW, 8'h12);
		wr(`OFS_CONTROL_STATUS, 8'h80);
		ack(1);
		rd(`OFS_CONTROL_STATUS, 8'h00);
		wr(`OFS_IRQ_STATUS, 8'h0F);
		wr(`OFS_IRQ_MASK, 8'h00);
	endtask
	task automatic t_timer1();
		wr(`OFS_T1_LOW, 8'hF0);
		wr(`OFS_T1_HIGH, 8'hF0);
		wr(`OFS_CLOCK_SELECT, 8'h10);
		wr(`OFS_MODE_CONFIG, 8'h67);
		i_pins.falls(1, 2);
		wait_for(1);
		chk("t1 pulse", {7'h0, hit}, 8'h01);
		rd(`OFS_CONTROL_STATUS, 8'h00);
		wr(`OFS_MODE_CONFIG, 8'h77);
		wr(`OFS_T1_LOW, 8'h33);
		repeat (300) @(posedge core_clk);
		rd(`OFS_T1_LOW, 8'h33);
	endtask
	task automatic t_gate();
		wr(`OFS_MODE_CONFIG, 8'h0A);
		wr(`OFS_CLOCK_SELECT, 8'h08);
		wr(`OFS_IRQ_STATUS, 8'h0F);
		wr(`OFS_IRQ_MASK, 8'h01);
		i_pins.set_gate(1'b0);
		wr(`OFS_CONTROL_STATUS, 8'h10);
		repeat (300) @(posedge core_clk);
		chk("irq", {7'h0, irq}, 8'h00);
		rd(`OFS_CONTROL_STATUS, 8'h12);
		i_pins.set_gate(1'b1);
		wait_for(0);
		chk("irq", {7'h0, hit}, 8'h01);
		rd(`OFS_CONTROL_STATUS, 8'h30);
		wr(`OFS_IRQ_MASK, 8'h00);
		repeat (3) @(posedge core_clk);
		chk("masked irq", {7'h0, irq}, 8'h00);
		wr(`OFS_IRQ_STATUS, 8'h01);
		wr(`OFS_IRQ_MASK, 8'h01);
		repeat (3) @(posedge core_clk);
		chk("cleared irq", {7'h0, irq}, 8'h00);
	endtask
	// 16-bit then 13-bit mode, counted on pin falls so the end value is exact
	task automatic t_modes();
		wr(`OFS_MODE_CONFIG, 8'h05);
		for (int m = 0; m < 2; m++) begin
			wr(`OFS_T0_HIGH, 8'hFF);
			wr(`OFS_T0_LOW, 8'hFC);
			wr(`OFS_CONTROL_STATUS, 8'h10);
			i_pins.falls(0, 4);
			rd(`OFS_T0_LOW, (m == 0) ? 8'h00 : 8'hE0);
			rd(`OFS_T0_HIGH, 8'h00);
			rd(`OFS_CONTROL_STATUS, 8'h30);
			wr(`OFS_MODE_CONFIG, 8'h04);
		end
	endtask
	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		resetn = 1'b0;
		reg_addr = '0;
		reg_wdata = '0;
		reg_write = 1'b0;
		reg_read = 1'b0;
		t1_ack = 1'b0;
		t0_ack = 1'b0;
		err_count = 0;
		n_compared = 0;
		repeat (10) @(posedge core_clk);
		resetn <= 1'b1;
		t_reset_map();
		t_split_low();
		t_split_high();
		t_timer1();
		t_gate();
		t_modes();
		end_of_test();
	end
	// About seventeen times the expected run
	initial begin
		#100000;
		err_count++;
		end_of_test();
	end
endmodule // tb_top
